// >>> hdl/cwd_pkg.sv
// Package for the configuration word decoder: register map, field layout, timing.
// Assumes a 50 MHz system clock and a 32-bit AXI4-Lite register bus.
package cwd_pkg;

   // ==========================================================
   // Register map
   localparam logic [15:0] CWD_OPT_WORD_ADDR  = 16'h2007;   // Word index, byte address is four times
   localparam logic [15:0] CWD_CTRL_ADDR      = 16'h2008;   // Programming mode, erase strobe
   localparam logic [15:0] CWD_STAT_ADDR      = 16'h2009;   // Decoded options and timer state
   localparam logic [15:0] CWD_GUARD_ADDR     = 16'h200A;   // Self-write address check
   localparam int          CWD_ADDR_W         = 18;
   localparam logic [13:0] CWD_WORD_ERASED    = 14'h3FFF;
   localparam logic [13:0] CWD_UNUSED_MASK    = 14'h1030;   // Bits 12, 5 and 4

   // ==========================================================
   // Field positions
   localparam int CWD_B_PROT   = 13;
   localparam int CWD_B_DBG    = 11;
   localparam int CWD_B_WRT_HI = 10;
   localparam int CWD_B_WRT_LO = 9;
   localparam int CWD_B_DPROT  = 8;
   localparam int CWD_B_LVP    = 7;
   localparam int CWD_B_BOR    = 6;
   localparam int CWD_B_POWERUP_DELAY_TIMER   = 3;
   localparam int CWD_B_WDT    = 2;

   // ==========================================================
   // Write guard limits
   localparam logic [12:0] CWD_LIM_100  = 13'h00FF;
   localparam logic [12:0] CWD_LIM_L07  = 13'h07FF;
   localparam logic [12:0] CWD_LIM_L0F  = 13'h0FFF;
   localparam logic [12:0] CWD_LIM_S03  = 13'h03FF;
   localparam logic [12:0] CWD_TOP_L    = 13'h1FFF;
   localparam logic [12:0] CWD_TOP_S    = 13'h0FFF;

   // ==========================================================
   // Timing
   localparam int CWD_CLK_HZ        = 50_000_000;
   localparam int CWD_POWERUP_DELAY_TIMER_MS       = 72;
   localparam int CWD_POWERUP_DELAY_TIMER_CYC      = CWD_CLK_HZ / 1000 * CWD_POWERUP_DELAY_TIMER_MS;
   localparam int CWD_OST_STABLE    = 1024;                 // System clock cycles to wait with crystal-ready held
   localparam int CWD_CNT_W         = 22;

   typedef enum logic [1:0] {
      CWD_OSC_LP = 2'b00,
      CWD_OSC_XT = 2'b01,
      CWD_OSC_HS = 2'b10,
      CWD_OSC_RC = 2'b11
   } cwd_osc_e;

   typedef struct packed {
      logic     program_protect_n;
      logic     debug_off;
      logic [1:0] self_write_guard_sel;
      logic     data_nvm_protect_n;
      logic     low_volt_prog_en;
      logic     brownout_reset_en;
      logic     powerup_delay_en_n;
      logic     watchdog_on;
      cwd_osc_e osc_mode_sel;
   } cwd_opts_s;

   function automatic logic [13:0] cwd_clean(input logic [13:0] w);
      return w | CWD_UNUSED_MASK;
   endfunction

endpackage

// >>> hdl/cwd_guard.sv
// Self-write guard: tells whether a program address lies in the protected range.
// Assumes the option word is already latched and stable.
`timescale 1ns/1ps
module cwd_guard
   import cwd_pkg::*;
(
   input  wire logic [1:0]  sel,
   input  wire logic        large_mem,
   input  wire logic [12:0] addr,
   output logic             blocked,
   output logic             out_range
);
   logic [12:0] lim;

   always_comb begin
      lim = '0;
      case (sel)
         2'b10:   lim = CWD_LIM_100;
         2'b01:   lim = large_mem ? CWD_LIM_L07 : CWD_LIM_S03;
         2'b00:   lim = large_mem ? CWD_LIM_L0F : CWD_LIM_L07;
         default: lim = '0;
      endcase
      out_range = addr > (large_mem ? CWD_TOP_L : CWD_TOP_S);
      blocked   = out_range || ((sel != 2'b11) && (addr <= lim));
   end
endmodule // cwd_guard

// >>> hdl/cwd_top.sv
// Configuration word decoder top: option word store, decode, start-up timers,
// sleep wake logic and AXI4-Lite slave.
// Assumes a single 50 MHz clock; pins reset and crystal-ready arrive asynchronous.
`timescale 1ns/1ps

// Contract
// - Erased word reads 3FFF
// - Programmed bits zero, unprogrammed bits one
// - Word at 2007, programming mode only
// - Top bit clear protects program memory
// - Unused bits always read one
// - Debug bit selects pin dedication
// - Large part write guard ranges
// - Small part write guard ranges
// - Data memory protect active low
// - Low voltage bit selects entry pin
// - Brown-out reset enable active high
// - Power-up timer enable active low
// - Watchdog enable active high
// - Low bits select oscillator mode
// - Power-up timer holds 72 ms once
// - Start-up timer waits for crystal
// - Watchdog disable only by word
// - Sleep ends on reset, watchdog, interrupt
module cwd_top
   import cwd_pkg::*;
#(
   parameter int POWERUP_DELAY_TIMER_CYCLES = CWD_POWERUP_DELAY_TIMER_CYC
)(
   input  wire logic        clock,
   input  wire logic        resetn,
   input  wire logic        clk_en,
   input  wire logic        large_mem,
   input  wire logic        osc_stable_pin,
   input  wire logic        ext_reset_n_pin,
   input  wire logic        watchdog_timeout,
   input  wire logic        irq_pending,
   input  wire logic        sleep_req,
   input  wire logic [CWD_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [CWD_ADDR_W-1:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output cwd_opts_s        opts_r,
   output logic             debug_pins_dedicated_r,
   output logic             prog_entry_pin_en_r,
   output logic             watchdog_run_r,
   output logic             hold_in_reset_r,
   output logic             asleep_r
);
   // ==========================================================
   // Storage and synchronisers
   // Option word is nonvolatile: resetn leaves it alone, only an erase restores it
   logic [13:0]           word_r = CWD_WORD_ERASED;
   logic                  prog_mode_r;
   logic [12:0]           guard_addr_r;
   logic [2:0]            osc_sync_r;
   logic [2:0]            ext_sync_r;
   logic                  osc_ok_r;
   logic                  ext_rst_n_r;
   logic                  latch_pend_r;
   logic [CWD_CNT_W-1:0]  powerup_delay_timer_cnt_r;
   logic                  powerup_delay_timer_done_r;
   logic [10:0]           ost_cnt_r;
   logic                  ost_done_r;
   logic                  blocked;
   logic                  out_range;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         osc_sync_r <= '0;
         ext_sync_r <= 3'b111;
         osc_ok_r   <= 1'b0;
         ext_rst_n_r <= 1'b1;
      end else if (clk_en) begin
         osc_sync_r <= {osc_sync_r[1:0], osc_stable_pin};
         ext_sync_r <= {ext_sync_r[1:0], ext_reset_n_pin};
         if (osc_sync_r[1] == osc_sync_r[2])
            osc_ok_r <= osc_sync_r[2];
         if (ext_sync_r[1] == ext_sync_r[2])
            ext_rst_n_r <= ext_sync_r[2];
      end
   end

   // ==========================================================
   // AXI4-Lite slave
   logic                  aw_have_r;
   logic                  w_have_r;
   logic [CWD_ADDR_W-1:0] aw_addr_r;
   logic [31:0]           w_data_r;
   logic [3:0]            w_strb_r;
   logic                  wr_fire;
   logic [15:0]           wr_idx;
   logic [15:0]           rd_idx;
   logic                  ctrl_wr;
   logic                  word_wr;
   logic                  guard_wr;

   function automatic logic [15:0] cwd_idx(input logic [CWD_ADDR_W-1:0] a);
      return a[CWD_ADDR_W-1:2];
   endfunction

   assign wr_fire  = aw_have_r && w_have_r && !s_axi_bvalid;
   assign wr_idx   = cwd_idx(aw_addr_r);
   assign rd_idx   = cwd_idx(s_axi_araddr);
   assign ctrl_wr  = wr_fire && (wr_idx == CWD_CTRL_ADDR);
   assign word_wr  = wr_fire && (wr_idx == CWD_OPT_WORD_ADDR) && prog_mode_r;
   assign guard_wr = wr_fire && (wr_idx == CWD_GUARD_ADDR);

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         aw_have_r     <= 1'b0;
         w_have_r      <= 1'b0;
         aw_addr_r     <= '0;
         w_data_r      <= '0;
         w_strb_r      <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'b00;
      end else if (clk_en) begin
         s_axi_awready <= !aw_have_r && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !w_have_r && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_have_r    <= 1'b0;
            w_have_r     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (ctrl_wr || word_wr || guard_wr) ? 2'b00 : 2'b10;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Programming mode and guard address
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         prog_mode_r  <= 1'b0;
         guard_addr_r <= '0;
      end else if (clk_en) begin
         if (ctrl_wr && w_strb_r[0])
            prog_mode_r <= w_data_r[0];
         if (guard_wr && (&w_strb_r[1:0]))
            guard_addr_r <= w_data_r[12:0];
      end
   end

   // Programming only clears bits; erase by writing ctrl bit 1 while already in programming mode
   // Kept across resetn so that a power-up sees the programmed timer options
   always_ff @(posedge clock) begin
      if (clk_en) begin
         if (ctrl_wr && w_strb_r[0] && w_data_r[1] && prog_mode_r)
            word_r <= CWD_WORD_ERASED;
         else if (word_wr && (&w_strb_r[1:0]))
            word_r <= cwd_clean(word_r & w_data_r[13:0]);
      end
   end

   logic [31:0] rd_val;
   logic        rd_ok;

   always_comb begin
      rd_val = '0;
      rd_ok  = 1'b1;
      case (rd_idx)
         CWD_OPT_WORD_ADDR: begin
            rd_ok  = prog_mode_r;
            rd_val = prog_mode_r ? {18'h0, cwd_clean(word_r)} : 32'h0;
         end
         CWD_CTRL_ADDR:  rd_val = {31'h0, prog_mode_r};
         CWD_STAT_ADDR:  rd_val = {16'h0, asleep_r, hold_in_reset_r, ost_done_r, powerup_delay_timer_done_r,
                                   1'b0, opts_r};
         CWD_GUARD_ADDR: rd_val = {16'h0, out_range, blocked, 1'b0, guard_addr_r};
         default:        rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= 2'b00;
      end else if (clk_en) begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_val;
            s_axi_rresp  <= rd_ok ? 2'b00 : 2'b10;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Option latch at reset release
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         latch_pend_r           <= 1'b1;
         opts_r                 <= cwd_opts_s'({CWD_WORD_ERASED[13], CWD_WORD_ERASED[11:6],
                                                CWD_WORD_ERASED[3:0]});
         debug_pins_dedicated_r <= 1'b0;
         prog_entry_pin_en_r    <= 1'b1;
         watchdog_run_r         <= 1'b1;
      end else if (clk_en) begin
         if (latch_pend_r || !ext_rst_n_r) begin
            latch_pend_r <= 1'b0;
            opts_r.program_protect_n    <= word_r[CWD_B_PROT];
            opts_r.debug_off            <= word_r[CWD_B_DBG];
            opts_r.self_write_guard_sel <= word_r[CWD_B_WRT_HI:CWD_B_WRT_LO];
            opts_r.data_nvm_protect_n   <= word_r[CWD_B_DPROT];
            opts_r.low_volt_prog_en     <= word_r[CWD_B_LVP];
            opts_r.brownout_reset_en    <= word_r[CWD_B_BOR];
            opts_r.powerup_delay_en_n   <= word_r[CWD_B_POWERUP_DELAY_TIMER];
            opts_r.watchdog_on          <= word_r[CWD_B_WDT];
            opts_r.osc_mode_sel         <= cwd_osc_e'(word_r[1:0]);
            debug_pins_dedicated_r      <= !word_r[CWD_B_DBG];
            prog_entry_pin_en_r         <= word_r[CWD_B_LVP];
            watchdog_run_r              <= word_r[CWD_B_WDT];
         end
      end
   end

   // ==========================================================
   // Start-up timers
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         powerup_delay_timer_cnt_r  <= '0;
         powerup_delay_timer_done_r <= 1'b0;
      end else if (clk_en && !latch_pend_r && !powerup_delay_timer_done_r) begin
         if (opts_r.powerup_delay_en_n)
            powerup_delay_timer_done_r <= 1'b1;
         else if (powerup_delay_timer_cnt_r == CWD_CNT_W'(POWERUP_DELAY_TIMER_CYCLES - 1))
            powerup_delay_timer_done_r <= 1'b1;
         else
            powerup_delay_timer_cnt_r <= powerup_delay_timer_cnt_r + 1'b1;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         ost_cnt_r  <= '0;
         ost_done_r <= 1'b0;
      end else if (clk_en && !latch_pend_r && !ost_done_r) begin
         if (opts_r.osc_mode_sel == CWD_OSC_RC)
            ost_done_r <= 1'b1;
         else if (!osc_ok_r)
            ost_cnt_r <= '0;
         else if (ost_cnt_r == 11'(CWD_OST_STABLE - 1))
            ost_done_r <= 1'b1;
         else
            ost_cnt_r <= ost_cnt_r + 1'b1;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         hold_in_reset_r <= 1'b1;
      end else if (clk_en) begin
         hold_in_reset_r <= !(powerup_delay_timer_done_r && ost_done_r) || !ext_rst_n_r;
      end
   end

   // ==========================================================
   // Sleep
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         asleep_r <= 1'b0;
      end else if (clk_en) begin
         if (!ext_rst_n_r || watchdog_timeout || irq_pending)
            asleep_r <= 1'b0;
         else if (sleep_req && !hold_in_reset_r)
            asleep_r <= 1'b1;
      end
   end

   cwd_guard u_guard (
      .sel       (opts_r.self_write_guard_sel),
      .large_mem (large_mem),
      .addr      (guard_addr_r),
      .blocked   (blocked),
      .out_range (out_range)
   );

   // ==========================================================
   // Checks
   a_unused_read_one: assert property (@(posedge clock) disable iff (!resetn)
      (word_r & CWD_UNUSED_MASK) == CWD_UNUSED_MASK)
      else $error("unused bits not one");
   a_prog_only_clear: assert property (@(posedge clock) disable iff (!resetn)
      (clk_en && word_wr && (&w_strb_r[1:0])) |=> ((word_r & ~$past(word_r)) == 14'h0))
      else $error("program set a bit");
   a_word_gated_prog: assert property (@(posedge clock) disable iff (!resetn)
      (s_axi_arvalid && s_axi_arready && rd_idx == CWD_OPT_WORD_ADDR && !prog_mode_r)
      |=> (s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0))
      else $error("word readable");
   a_debug_pins_map: assert property (@(posedge clock) disable iff (!resetn)
      !latch_pend_r |-> (debug_pins_dedicated_r == !opts_r.debug_off))
      else $error("debug pins");
   a_lvp_pin_map: assert property (@(posedge clock) disable iff (!resetn)
      !latch_pend_r |-> (prog_entry_pin_en_r == opts_r.low_volt_prog_en))
      else $error("lvp pin");
   a_wdt_only_word: assert property (@(posedge clock) disable iff (!resetn)
      !latch_pend_r |-> (watchdog_run_r == opts_r.watchdog_on))
      else $error("watchdog");
   a_opts_held: assert property (@(posedge clock) disable iff (!resetn)
      (!latch_pend_r && ext_rst_n_r && $past(ext_rst_n_r)) |=> $stable(opts_r))
      else $error("opts moved");
   a_hold_until_timers: assert property (@(posedge clock) disable iff (!resetn)
      (!powerup_delay_timer_done_r || !ost_done_r) |=> hold_in_reset_r)
      else $error("released early");
   a_wake_on_event: assert property (@(posedge clock) disable iff (!resetn)
      (clk_en && asleep_r && (watchdog_timeout || irq_pending)) |=> !asleep_r)
      else $error("no wake");
   a_powerup_delay_timer_skip: assert property (@(posedge clock) disable iff (!resetn)
      (clk_en && !latch_pend_r && !powerup_delay_timer_done_r && opts_r.powerup_delay_en_n) |=> powerup_delay_timer_done_r)
      else $error("powerup_delay_timer not skipped");
   a_powerup_delay_timer_runs: assert property (@(posedge clock) disable iff (!resetn)
      (clk_en && !latch_pend_r && !powerup_delay_timer_done_r && !opts_r.powerup_delay_en_n
       && powerup_delay_timer_cnt_r != CWD_CNT_W'(POWERUP_DELAY_TIMER_CYCLES - 1)) |=> !powerup_delay_timer_done_r)
      else $error("power-up delay cut short");
   a_ost_restart: assert property (@(posedge clock) disable iff (!resetn)
      (clk_en && !latch_pend_r && !ost_done_r && !osc_ok_r && opts_r.osc_mode_sel != CWD_OSC_RC)
      |=> (ost_cnt_r == 11'h000 && !ost_done_r))
      else $error("crystal wait not restarted");

   c_prog_write: cover property (@(posedge clock) disable iff (!resetn) word_wr);
   c_released:   cover property (@(posedge clock) disable iff (!resetn) $fell(hold_in_reset_r));
   c_woke:       cover property (@(posedge clock) disable iff (!resetn) $fell(asleep_r));
   c_blocked:    cover property (@(posedge clock) disable iff (!resetn) blocked && !out_range);
   c_ost_count:  cover property (@(posedge clock) disable iff (!resetn)
      $rose(ost_done_r) && opts_r.osc_mode_sel != CWD_OSC_RC);

endmodule // cwd_top

// >>> sim/cwd_prog_model.sv
// Programmer model: AXI4-Lite master that reaches the option word and its controls.
// Assumes the slave answers in its own time; the bench watchdog ends any hang.
`timescale 1ns/1ps
module cwd_prog_model
   import cwd_pkg::*;
(
   input  wire logic                  clock,
   output logic [CWD_ADDR_W-1:0]      awaddr,
   output logic                       awvalid,
   input  wire logic                  awready,
   output logic [31:0]                wdata,
   output logic [3:0]                 wstrb,
   output logic                       wvalid,
   input  wire logic                  wready,
   input  wire logic [1:0]            bresp,
   input  wire logic                  bvalid,
   output logic                       bready,
   output logic [CWD_ADDR_W-1:0]      araddr,
   output logic                       arvalid,
   input  wire logic                  arready,
   input  wire logic [31:0]           rdata,
   input  wire logic [1:0]            rresp,
   input  wire logic                  rvalid,
   output logic                       rready
);
   initial begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
   end

   // Released payloads flip so that a stale value is never mistaken for a live one
   task automatic wr(input logic [CWD_ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge clock);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge clock);
         if (awvalid && awready) begin
            awvalid <= 1'b0;
            awaddr <= ~a;
         end
         if (wvalid && wready) begin
            wvalid <= 1'b0;
            wdata <= ~d;
         end
         if (bvalid) break;
      end
      r = bresp;
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [CWD_ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clock);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge clock);
         if (arvalid && arready) begin
            arvalid <= 1'b0;
            araddr <= ~a;
         end
         if (rvalid) break;
      end
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
endmodule // cwd_prog_model

// >>> sim/configuration_word_decoder_tb.sv
// Bench for the option word decoder: programs words, relatches them, checks decode, guard and sleep.
// Assumes cwd_top and the programmer model; all bus traffic goes through the model's tasks.
`timescale 1ns/1ps
module configuration_word_decoder_tb;
   import cwd_pkg::*;
   localparam logic [17:0] A_WORD = {CWD_OPT_WORD_ADDR, 2'b00};
   localparam logic [17:0] A_CTRL = {CWD_CTRL_ADDR, 2'b00};
   localparam logic [17:0] A_STAT = {CWD_STAT_ADDR, 2'b00};
   localparam logic [17:0] A_GRD  = {CWD_GUARD_ADDR, 2'b00};
   logic        clock = 1'b0;
   logic        resetn = 1'b0;
   logic        lm = 1'b1, osc_ok = 1'b1, ext_n = 1'b1, wdto = 1'b0, irq = 1'b0, slp = 1'b0;
   logic [17:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, rsp;
   logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   cwd_opts_s   opts;
   logic        dbg, pe, wdr, hold, asleep;
   logic [15:0] rnd = 16'hD29C;
   logic [13:0] w, exp;
   logic [10:0] last;
   logic [12:0] a;
   int          err_total = 0;
   int          num_checks = 0;

   always #10 clock = ~clock;

   cwd_top #(.POWERUP_DELAY_TIMER_CYCLES(20)) dut_u (
      .clock(clock), .resetn(resetn), .clk_en(1'b1), .large_mem(lm), .osc_stable_pin(osc_ok),
      .ext_reset_n_pin(ext_n), .watchdog_timeout(wdto), .irq_pending(irq), .sleep_req(slp),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .opts_r(opts), .debug_pins_dedicated_r(dbg), .prog_entry_pin_en_r(pe),
      .watchdog_run_r(wdr), .hold_in_reset_r(hold), .asleep_r(asleep));

   cwd_prog_model prog_u (
      .clock(clock), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready));

   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction

   function automatic logic [10:0] dec(input logic [13:0] x);
      return {x[13], x[11:6], x[3:0]};
   endfunction

   // Upper end of the guarded range; code 11 guards nothing and is handled by the caller
   function automatic logic [12:0] lim(input logic [1:0] s, input logic l);
      case (s)
         2'b10: return 13'h00FF;
         2'b01: return l ? 13'h07FF : 13'h03FF;
         default: return l ? 13'h0FFF : 13'h07FF;
      endcase
   endfunction

   task automatic chk(input logic [39:0] seen, input logic [39:0] want);
      num_checks++;
      if (seen !== want) begin
         err_total++;
         $display("Error at %0t: saw %h expected %h", $time, seen, want);
      end
   endtask

   task automatic final_report;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // Pulse the external reset pin long enough to pass its synchroniser
   task automatic ext_pulse;
      ext_n <= 1'b0;
      repeat (6) @(posedge clock);
      chk(hold, 1'b1);
      ext_n <= 1'b1;
      repeat (8) @(posedge clock);
   endtask

   initial begin
      repeat (2) @(posedge clock);
      chk({opts, dbg, pe, wdr, hold, asleep}, {11'h7FF, 5'b01110});
      resetn <= 1'b1;
      repeat (8) @(posedge clock);
      chk({opts, hold}, {11'h7FF, 1'b0});
      $display("test reset done");

      for (int k = 0; k < 3; k++) begin
         slp <= 1'b1;
         @(posedge clock);
         slp <= 1'b0;
         repeat (3) @(posedge clock);
         chk(asleep, 1'b1);
         if (k == 0) irq <= 1'b1;
         else if (k == 1) wdto <= 1'b1;
         else ext_n <= 1'b0;
         repeat (6) @(posedge clock);
         chk(asleep, 1'b0);
         irq <= 1'b0;
         wdto <= 1'b0;
         ext_n <= 1'b1;
         repeat (8) @(posedge clock);
      end
      $display("test sleep done");

      prog_u.rd(A_WORD, rd, rsp);
      chk({rsp, rd}, {2'b10, 32'h0});
      prog_u.wr(A_WORD, 32'h0, rsp);
      chk(rsp, 2'b10);
      prog_u.rd(A_STAT + 18'h00010, rd, rsp);
      chk(rsp, 2'b10);
      prog_u.wr(A_CTRL, 32'h1, rsp);
      prog_u.rd(A_WORD, rd, rsp);
      chk({rsp, rd}, {2'b00, 32'h3FFF});
      $display("test access done");

      last = 11'h7FF;
      for (int i = 0; i < 8; i++) begin
         rnd = lfsr(rnd);
         w = rnd[13:0];
         w[10:9] = i[1:0];
         w[1:0] = i[1:0] + 2'b01;
         prog_u.wr(A_CTRL, 32'h3, rsp);
         prog_u.wr(A_WORD, {18'h0, w}, rsp);
         exp = w | 14'h1030;
         prog_u.rd(A_WORD, rd, rsp);
         chk(rd, exp);
         chk(opts, last);
         ext_pulse();
         chk(opts, dec(exp));
         chk({dbg, pe, wdr}, {~exp[11], exp[7], exp[2]});
         prog_u.rd(A_STAT, rd, rsp);
         chk(rd[15:0], {4'b0011, 1'b0, dec(exp)});
         last = dec(exp);
         for (int l = 0; l < 2; l++) begin
            lm <= l[0];
            for (int j = 0; j < 3; j++) begin
               a = (w[10:9] == 2'b11) ? 13'h0000 : lim(w[10:9], l[0]);
               a = (j == 2) ? 13'h1000 : a + j[12:0];
               prog_u.wr(A_GRD, {19'h0, a}, rsp);
               prog_u.rd(A_GRD, rd, rsp);
               chk({rd[15:14], rd[12:0]}, {!l[0] && a > 13'h0FFF,
                   (!l[0] && a > 13'h0FFF) || (w[10:9] != 2'b11 && a <= lim(w[10:9], l[0])), a});
            end
         end
      end
      $display("test decode done");

      // Power-up with a retained word: power-up delay on, standard crystal, both timers run
      prog_u.wr(A_CTRL, 32'h3, rsp);
      prog_u.wr(A_WORD, 32'h3FF5, rsp);
      resetn <= 1'b0;
      repeat (2) @(posedge clock);
      chk({opts, hold, asleep}, {11'h7FF, 2'b10});
      resetn <= 1'b1;
      repeat (500) @(posedge clock);
      chk({opts, hold}, {11'h7F5, 1'b1});
      prog_u.rd(A_STAT, rd, rsp);
      chk(rd[15:12], 4'b0101);
      repeat (600) @(posedge clock);
      chk(hold, 1'b0);
      $display("test power-up done");
      final_report();
   end

   initial begin
      repeat (40000) @(posedge clock);
      err_total++;
      final_report();
   end
endmodule // configuration_word_decoder_tb
